// File: inc/mhtd_pkg.sv
package mhtd_pkg;
    // -------------------------------------------------------------
    // geometry
    // -------------------------------------------------------------
    localparam int NCH     = 96;
    localparam int LDEPTH  = 16;
    localparam int NSLOT   = 8;
    localparam int EVW     = NCH * LDEPTH;
    localparam int BADDR_W = 14;
    // -------------------------------------------------------------
    // timing, in picoseconds, and derived cycle counts
    // -------------------------------------------------------------
    localparam int CLK_PS  = 50000;
    localparam int LSB_PS  = 500;
    localparam int FS_PS   = 32768000;
    localparam int SEP_PS  = 10000;
    localparam int TICKS   = CLK_PS / LSB_PS;
    localparam int FS_CYC  = FS_PS / CLK_PS;
    // -------------------------------------------------------------
    // register byte offsets
    // -------------------------------------------------------------
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_DEPTH  = 8'h04;
    localparam logic [7:0] A_RANGE  = 8'h08;
    localparam logic [7:0] A_TMO    = 8'h0C;
    localparam logic [7:0] A_STAT   = 8'h10;
    localparam logic [7:0] A_HLEN   = 8'h14;
    localparam logic [7:0] A_RDATA  = 8'h18;
    localparam logic [7:0] A_REL    = 8'h1C;
    localparam logic [7:0] A_EDGE   = 8'h20;
    localparam logic [7:0] A_EDGE_E = 8'h38;
    // -------------------------------------------------------------
    // fields and reset values
    // -------------------------------------------------------------
    localparam int CTRL_EN   = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_EXT  = 2;
    localparam logic [2:0]  CTRL_RST  = 3'h0;
    localparam logic [4:0]  DEPTH_RST = 5'h10;
    localparam logic [16:0] RANGE_RST = 17'h10000;
    localparam logic [9:0]  TMO_RST   = 10'h28F;
    localparam logic [1:0]  EDGE_RST  = 2'h1;
    localparam logic [1:0]  RESP_OK   = 2'h0;
    localparam logic [1:0]  RESP_ERR  = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ARM  = 3'h1,
        ST_ACQ  = 3'h3,
        ST_XFER = 3'h2,
        ST_WAIT = 3'h6
    } mhtd_st_t;
endpackage

// File: src/mhtd_top.sv
// What this block does
// - 96 channels timestamped in 500 ps units, stepping once per 50 ns clock
// - per-channel LIFO holds times until buffered
// - LIFO depth programmable 1 to 16
// - full scale range programmable up to 32.768 us
// - common start then up to 16 hits
// - common stop latched as shared reference
// - per-channel rising, falling or both edges
// - edges on one channel under a clock apart are not resolved
// - over 16 hits keeps latest 16
// - only first common pulse per event counts
// - programmed enable arms acquisition
// - start begins acquisition, timeout ends it
// - no hits after window expires
// - external timeout input ends acquisition
// - acquisition never exceeds 32.768 us
// - event moved into eight-event circular buffer
// - rearms itself once event is buffered
// - readout runs alongside acquisition and buffering
`timescale 1ns/100ps
module mhtd_top
    import mhtd_pkg::*;
(
    input  wire logic           i_clk,
    input  wire logic           i_rst_n,
    input  wire logic [NCH-1:0] i_hit,
    input  wire logic           i_common,
    input  wire logic           i_ext_tmo,
    input  wire logic [7:0]     i_awaddr,
    input  wire logic           i_awvalid,
    output logic                o_awready,
    input  wire logic [31:0]    i_wdata,
    input  wire logic [3:0]     i_wstrb,
    input  wire logic           i_wvalid,
    output logic                o_wready,
    output logic [1:0]          o_bresp,
    output logic                o_bvalid,
    input  wire logic           i_bready,
    input  wire logic [7:0]     i_araddr,
    input  wire logic           i_arvalid,
    output logic                o_arready,
    output logic [31:0]         o_rdata,
    output logic [1:0]          o_rresp,
    output logic                o_rvalid,
    input  wire logic           i_rready,
    output logic                o_acq
);
    // -------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------
    logic [NCH-1:0] hs1_q, hs2_q, hs3_q;
    logic [2:0]     cs_q;
    logic [1:0]     es_q;

    // third hit stage only feeds the edge detector, never stage one
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            hs1_q <= '0;
            hs2_q <= '0;
            hs3_q <= '0;
            cs_q  <= 3'h0;
            es_q  <= 2'h0;
        end else begin
            hs1_q <= i_hit;
            hs2_q <= hs1_q;
            hs3_q <= hs2_q;
            cs_q  <= {cs_q[1:0], i_common};
            es_q  <= {es_q[0], i_ext_tmo};
        end
    end

    logic com_rise;
    assign com_rise = cs_q[1] & ~cs_q[2];

    // -------------------------------------------------------------
    // registers and state
    // -------------------------------------------------------------
    mhtd_st_t        st_q, st_d;
    logic [2:0]      ctrl_q, ctrl_d;
    logic [4:0]      depth_q, depth_d;
    logic [16:0]     range_q, range_d;
    logic [9:0]      tmo_q, tmo_d;
    logic [2*NCH-1:0] edge_q, edge_d;
    logic [9:0]      tmr_q, tmr_d;
    logic [15:0]     ref_q, ref_d;
    logic            com_q, com_d;
    logic [6:0]      xch_q, xch_d;
    logic [10:0]     wcnt_q, wcnt_d;
    logic [2:0]      wsl_q, wsl_d, rsl_q, rsl_d;
    logic [3:0]      used_q, used_d;
    logic [10:0]     rptr_q, rptr_d;
    logic            awh_q, awh_d, wh_q, wh_d;
    logic [7:0]      awa_q, awa_d;
    logic [31:0]     wd_q, wd_d;
    logic [3:0]      ws_q, ws_d;
    logic            bv_q, bv_d, rv_q, rv_d;
    logic [1:0]      br_q, br_d, rr_q, rr_d;
    logic [31:0]     rd_q, rd_d;

    logic [4:0]  cnt_q [NCH];
    logic [3:0]  wp_q [NCH];
    logic [16:0] lifo_q [NCH][LDEPTH];
    logic [23:0] ebuf_q [NSLOT*EVW];
    logic [10:0] elen_q [NSLOT];

    // -------------------------------------------------------------
    // timestamps and acquisition window
    // -------------------------------------------------------------
    logic [4:0]  depth;
    logic [3:0]  dmax;
    logic [16:0] prod;
    logic [15:0] stamp;
    logic        smode, hit_ok, acq_end, lifo_clr, pop, bwe, commit;
    logic        rel;
    logic [NCH-1:0] wr;

    // 0 clamps to 1 and anything over 16 clamps to 16
    assign depth = (depth_q == 5'h0) ? 5'h1 : ((depth_q > 5'h10) ? 5'h10 : depth_q);
    assign dmax  = 4'(depth - 5'h1);
    // cycle count scaled to 500 ps units, 655 cycles stays under 2^16
    assign prod  = {7'h0, tmr_q} * 17'(TICKS);
    assign stamp = prod[15:0];
    assign smode = ctrl_q[CTRL_STOP];
    assign o_acq = (st_q == ST_ACQ);
    // start mode drops hits past the range at once; stop mode filters on transfer
    assign hit_ok = o_acq && (smode || ({1'b0, stamp} < range_q));
    assign acq_end = (ctrl_q[CTRL_EXT] && es_q[1])
                   || (tmr_q == 10'(FS_CYC - 1))
                   || (!smode && (10'(tmr_q + 10'h1) >= tmo_q))
                   || (smode && com_rise);
    assign lifo_clr = (st_q == ST_IDLE);

    // -------------------------------------------------------------
    // per-channel edge select and LIFO ring
    // -------------------------------------------------------------
    // one hit per channel per clock: edges under a clock apart merge
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic [4:0] cnt_d;
        logic [3:0] wp_d;
        logic       rise, fall;
        assign rise  = hs2_q[c] & ~hs3_q[c];
        assign fall  = ~hs2_q[c] & hs3_q[c];
        assign wr[c] = hit_ok & ((rise & edge_q[2*c]) | (fall & edge_q[2*c+1]));
        // ring of depth entries, newest overwrites oldest when full
        always_comb begin
            cnt_d = cnt_q[c];
            wp_d  = wp_q[c];
            if (lifo_clr) begin
                cnt_d = 5'h0;
                wp_d  = 4'h0;
            end else if (wr[c]) begin
                wp_d = (wp_q[c] >= dmax) ? 4'h0 : 4'(wp_q[c] + 4'h1);
                if (cnt_q[c] < depth) begin
                    cnt_d = 5'(cnt_q[c] + 5'h1);
                end
            end else if (pop && (xch_q == 7'(c))) begin
                wp_d  = (wp_q[c] == 4'h0) ? dmax : 4'(wp_q[c] - 4'h1);
                cnt_d = 5'(cnt_q[c] - 5'h1);
            end
        end
        always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
                cnt_q[c] <= 5'h0;
                wp_q[c]  <= 4'h0;
            end else begin
                cnt_q[c] <= cnt_d;
                wp_q[c]  <= wp_d;
            end
            if (wr[c]) begin
                lifo_q[c][wp_q[c]] <= {fall, stamp};
            end
        end
    end

    // -------------------------------------------------------------
    // transfer datapath
    // -------------------------------------------------------------
    logic [3:0]  top;
    logic [16:0] ent;
    logic [15:0] tval;
    logic        keep, xempty, xlast;

    assign top    = (wp_q[xch_q] == 4'h0) ? dmax : 4'(wp_q[xch_q] - 4'h1);
    assign ent    = lifo_q[xch_q][top];
    assign tval   = smode ? 16'(ref_q - ent[15:0]) : ent[15:0];
    assign keep   = {1'b0, tval} < range_q;
    assign xempty = (cnt_q[xch_q] == 5'h0);
    assign xlast  = (xch_q == 7'(NCH - 1));
    assign pop    = (st_q == ST_XFER) && !xempty;
    assign bwe    = pop && keep;
    assign commit = (st_q == ST_XFER) && xempty && xlast;

    // -------------------------------------------------------------
    // acquisition state machine
    // -------------------------------------------------------------
    always_comb begin
        st_d   = st_q;
        tmr_d  = tmr_q;
        ref_d  = ref_q;
        com_d  = com_q;
        xch_d  = xch_q;
        wcnt_d = wcnt_q;
        wsl_d  = wsl_q;
        case (st_q)
            ST_IDLE: begin
                if (ctrl_q[CTRL_EN]) begin
                    st_d = ST_ARM;
                end
            end
            ST_ARM: begin
                tmr_d = 10'h0;
                com_d = 1'b0;
                if (!ctrl_q[CTRL_EN]) begin
                    st_d = ST_IDLE;
                end else if (smode || com_rise) begin
                    st_d  = ST_ACQ;
                    com_d = !smode;
                end
            end
            ST_ACQ: begin
                // later common pulses in start mode change nothing
                tmr_d = 10'(tmr_q + 10'h1);
                if (acq_end) begin
                    st_d   = ST_XFER;
                    ref_d  = stamp;
                    com_d  = com_q | com_rise;
                    xch_d  = 7'h0;
                    wcnt_d = 11'h0;
                end
            end
            ST_XFER: begin
                if (bwe) begin
                    wcnt_d = 11'(wcnt_q + 11'h1);
                end
                if (xempty && !xlast) begin
                    xch_d = 7'(xch_q + 7'h1);
                end else if (commit) begin
                    wsl_d = 3'(wsl_q + 3'h1);
                    // the slot just filled may have been the last free one
                    if (used_d == 4'(NSLOT)) begin
                        st_d = ST_WAIT;
                    end else begin
                        st_d = ctrl_q[CTRL_EN] ? ST_ARM : ST_IDLE;
                    end
                end
            end
            ST_WAIT: begin
                if (used_q != 4'(NSLOT)) begin
                    st_d = ctrl_q[CTRL_EN] ? ST_ARM : ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_q   <= ST_IDLE;
            tmr_q  <= 10'h0;
            ref_q  <= 16'h0;
            com_q  <= 1'b0;
            xch_q  <= 7'h0;
            wcnt_q <= 11'h0;
            wsl_q  <= 3'h0;
        end else begin
            st_q   <= st_d;
            tmr_q  <= tmr_d;
            ref_q  <= ref_d;
            com_q  <= com_d;
            xch_q  <= xch_d;
            wcnt_q <= wcnt_d;
            wsl_q  <= wsl_d;
        end
    end

    // -------------------------------------------------------------
    // circular event buffer, separate write and read ports
    // -------------------------------------------------------------
    logic [BADDR_W-1:0] waddr, raddr;
    logic [10:0]        hlen;
    logic [23:0]        rword;

    assign waddr = BADDR_W'(BADDR_W'(wsl_q) * BADDR_W'(EVW) + BADDR_W'(wcnt_q));
    assign raddr = BADDR_W'(BADDR_W'(rsl_q) * BADDR_W'(EVW) + BADDR_W'(rptr_q));
    assign hlen  = (used_q == 4'h0) ? 11'h0 : elen_q[rsl_q];
    assign rword = (rptr_q < hlen) ? ebuf_q[raddr] : 24'h0;

    // channel, phase, time word; readout never stalls the writer
    always_ff @(posedge i_clk) begin
        if (bwe) begin
            ebuf_q[waddr] <= {xch_q, ent[16], tval};
        end
        if (commit) begin
            elen_q[wsl_q] <= wcnt_q;
        end
    end

    // -------------------------------------------------------------
    // AXI4-Lite slave and register file
    // -------------------------------------------------------------
    function automatic logic [31:0] wmrg(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = n[8*b +: 8];
            end
        end
        return r;
    endfunction

    logic        do_wr, do_rd, eh_w, eh_r;
    logic [2:0]  ei_w, ei_r;
    logic [31:0] m;

    assign o_awready = !awh_q && !bv_q;
    assign o_wready  = !wh_q && !bv_q;
    assign o_arready = !rv_q;
    assign o_bvalid  = bv_q;
    assign o_bresp   = br_q;
    assign o_rvalid  = rv_q;
    assign o_rresp   = rr_q;
    assign o_rdata   = rd_q;
    assign do_wr = awh_q && wh_q;
    assign do_rd = i_arvalid && !rv_q;
    assign eh_w  = (awa_q >= A_EDGE) && (awa_q < A_EDGE_E) && (awa_q[1:0] == 2'h0);
    assign eh_r  = (i_araddr >= A_EDGE) && (i_araddr < A_EDGE_E) && (i_araddr[1:0] == 2'h0);
    assign ei_w  = 3'(8'(awa_q - A_EDGE) >> 2);
    assign ei_r  = 3'(8'(i_araddr - A_EDGE) >> 2);
    assign rel   = do_wr && (awa_q == A_REL) && (used_q != 4'h0);

    // address and data are held separately, answered once both are in
    always_comb begin
        awh_d   = awh_q;
        awa_d   = awa_q;
        wh_d    = wh_q;
        wd_d    = wd_q;
        ws_d    = ws_q;
        bv_d    = bv_q;
        br_d    = br_q;
        rv_d    = rv_q;
        rr_d    = rr_q;
        rd_d    = rd_q;
        ctrl_d  = ctrl_q;
        depth_d = depth_q;
        range_d = range_q;
        tmo_d   = tmo_q;
        edge_d  = edge_q;
        rsl_d   = rsl_q;
        rptr_d  = rptr_q;
        m       = 32'h0;
        if (i_awvalid && o_awready) begin
            awh_d = 1'b1;
            awa_d = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            wh_d = 1'b1;
            wd_d = i_wdata;
            ws_d = i_wstrb;
        end
        if (bv_q && i_bready) begin
            bv_d = 1'b0;
        end
        if (do_wr) begin
            awh_d = 1'b0;
            wh_d  = 1'b0;
            bv_d  = 1'b1;
            br_d  = RESP_OK;
            case (awa_q)
                A_CTRL:  ctrl_d  = 3'(wmrg({29'h0, ctrl_q}, wd_q, ws_q));
                A_DEPTH: depth_d = 5'(wmrg({27'h0, depth_q}, wd_q, ws_q));
                A_RANGE: range_d = 17'(wmrg({15'h0, range_q}, wd_q, ws_q));
                A_TMO:   tmo_d   = 10'(wmrg({22'h0, tmo_q}, wd_q, ws_q));
                A_REL: begin
                    if (used_q != 4'h0) begin
                        rsl_d  = 3'(rsl_q + 3'h1);
                        rptr_d = 11'h0;
                    end
                end
                default: begin
                    if (eh_w) begin
                        edge_d[32*ei_w +: 32] = wmrg(edge_q[32*ei_w +: 32], wd_q, ws_q);
                    end else begin
                        br_d = RESP_ERR;
                    end
                end
            endcase
        end
        if (rv_q && i_rready) begin
            rv_d = 1'b0;
        end
        if (do_rd) begin
            rv_d = 1'b1;
            rr_d = RESP_OK;
            case (i_araddr)
                A_CTRL:  m = {29'h0, ctrl_q};
                A_DEPTH: m = {27'h0, depth_q};
                A_RANGE: m = {15'h0, range_q};
                A_TMO:   m = {22'h0, tmo_q};
                A_STAT:  m = {24'h0, used_q, st_q, com_q};
                A_HLEN:  m = {21'h0, hlen};
                A_RDATA: begin
                    m = {8'h0, rword};
                    if (rptr_q < hlen) begin
                        rptr_d = 11'(rptr_q + 11'h1);
                    end
                end
                A_REL:   m = 32'h0;
                default: begin
                    if (eh_r) begin
                        m = edge_q[32*ei_r +: 32];
                    end else begin
                        rr_d = RESP_ERR;
                    end
                end
            endcase
            rd_d = m;
        end
    end

    // commit and release in one cycle cancel, so no event is lost
    assign used_d = 4'(used_q + {3'h0, commit} - {3'h0, rel});

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            awh_q   <= 1'b0;
            awa_q   <= 8'h0;
            wh_q    <= 1'b0;
            wd_q    <= 32'h0;
            ws_q    <= 4'h0;
            bv_q    <= 1'b0;
            br_q    <= RESP_OK;
            rv_q    <= 1'b0;
            rr_q    <= RESP_OK;
            rd_q    <= 32'h0;
            ctrl_q  <= CTRL_RST;
            depth_q <= DEPTH_RST;
            range_q <= RANGE_RST;
            tmo_q   <= TMO_RST;
            edge_q  <= {NCH{EDGE_RST}};
            rsl_q   <= 3'h0;
            rptr_q  <= 11'h0;
            used_q  <= 4'h0;
        end else begin
            awh_q   <= awh_d;
            awa_q   <= awa_d;
            wh_q    <= wh_d;
            wd_q    <= wd_d;
            ws_q    <= ws_d;
            bv_q    <= bv_d;
            br_q    <= br_d;
            rv_q    <= rv_d;
            rr_q    <= rr_d;
            rd_q    <= rd_d;
            ctrl_q  <= ctrl_d;
            depth_q <= depth_d;
            range_q <= range_d;
            tmo_q   <= tmo_d;
            edge_q  <= edge_d;
            rsl_q   <= rsl_d;
            rptr_q  <= rptr_d;
            used_q  <= used_d;
        end
    end

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    property p_sat;
        @(posedge i_clk) disable iff (!i_rst_n) cnt_q[0] <= depth;
    endproperty
    a_sat: assert property (p_sat) else $error("lifo count above depth");
    property p_keep16;
        @(posedge i_clk) disable iff (!i_rst_n)
        (wr[0] && cnt_q[0] == depth && !lifo_clr) |=> (cnt_q[0] == $past(depth));
    endproperty
    a_keep16: assert property (p_keep16) else $error("full lifo count moved");
    property p_cap;
        @(posedge i_clk) disable iff (!i_rst_n) o_acq |-> (tmr_q < 10'(FS_CYC));
    endproperty
    a_cap: assert property (p_cap) else $error("acquisition beyond full scale");
    property p_win;
        @(posedge i_clk) disable iff (!i_rst_n) (wr[0] && !smode) |-> ({1'b0, stamp} < range_q);
    endproperty
    a_win: assert property (p_win) else $error("hit outside window");
    property p_start;
        @(posedge i_clk) disable iff (!i_rst_n)
        (st_q == ST_ARM && ctrl_q[CTRL_EN] && !smode && com_rise) |=> (o_acq && tmr_q == 10'h0) ##1 (tmr_q == 10'h1);
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_ext;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_acq && ctrl_q[CTRL_EXT] && es_q[1]) |=> (st_q == ST_XFER);
    endproperty
    a_ext: assert property (p_ext) else $error("external timeout ignored");
    property p_ign;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_acq && !smode && com_rise && !acq_end) |=> (o_acq && tmr_q == 10'($past(tmr_q) + 10'h1));
    endproperty
    a_ign: assert property (p_ign) else $error("second common pulse acted");
    property p_stop;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_acq && smode && com_rise) |=> (st_q == ST_XFER && ref_q == $past(stamp));
    endproperty
    a_stop: assert property (p_stop) else $error("stop not latched");
    property p_full;
        @(posedge i_clk) disable iff (!i_rst_n)
        (commit && used_d == 4'(NSLOT)) |=> (st_q == ST_WAIT) throughout (used_q == 4'(NSLOT))[*1];
    endproperty
    a_full: assert property (p_full) else $error("rearmed with buffer full");
    property p_rearm;
        @(posedge i_clk) disable iff (!i_rst_n)
        (commit && used_d != 4'(NSLOT) && ctrl_q[CTRL_EN]) |=> (st_q == ST_ARM);
    endproperty
    a_rearm: assert property (p_rearm) else $error("no rearm after buffering");
    c_start: cover property (@(posedge i_clk) disable iff (!i_rst_n) !smode && o_acq ##1 st_q == ST_XFER);
    c_stop:  cover property (@(posedge i_clk) disable iff (!i_rst_n) smode && o_acq && com_rise);
    c_wait:  cover property (@(posedge i_clk) disable iff (!i_rst_n) st_q == ST_WAIT ##1 st_q == ST_ARM);
    c_rel:   cover property (@(posedge i_clk) disable iff (!i_rst_n) rel && commit);
endmodule

// File: testbench/mhtd_src.sv
`timescale 1ns/100ps
// -------------------------------------------------------------
// far side: discriminator outputs and common pulse source
// -------------------------------------------------------------
module mhtd_src
    import mhtd_pkg::*;
(
    input  wire logic      i_clk,
    output logic [NCH-1:0] o_hit,
    output logic           o_common,
    output logic           o_ext_tmo
);
    // quiet lines at start; external timeout left low so the internal timeout or the stop ends the window
    initial begin
        o_hit     = '0;
        o_common  = 1'b0;
        o_ext_tmo = 1'b0;
    end
    // common pulse at c0 and a second one two clocks later, three toggles on one channel
    task automatic event_on(input int ch, input int c0);
        for (int k = 0; k < 14; k++) begin
            @(posedge i_clk);
            o_common <= (k == c0 || k == c0 + 2);
            if (k == 5 || k == 7 || k == 9) o_hit[ch] <= ~o_hit[ch];
        end
    endtask
endmodule

// File: testbench/tb_mhtd_top.sv
`timescale 1ns/100ps
module tb_mhtd_top
    import mhtd_pkg::*;
;
    logic            i_clk = 1'b0;
    logic            i_rst_n = 1'b0;
    logic [NCH-1:0]  hit;
    logic            com, ext, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [7:0]      awa = 8'h00, ara = 8'h00;
    logic [31:0]     wd = 32'h0, o_rdata;
    logic [1:0]      o_bresp, o_rresp;
    logic            o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_acq;
    logic [33:0]     exp_q[$];
    logic [1:0]      exp_b[$];
    int              n_errors = 0, comparisons = 0, cyc = 0, ch;
    mhtd_src src (.i_clk(i_clk), .o_hit(hit), .o_common(com), .o_ext_tmo(ext));
    mhtd_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hit(hit), .i_common(com), .i_ext_tmo(ext),
        .i_awaddr(awa), .i_awvalid(awv), .o_awready(o_awready), .i_wdata(wd), .i_wstrb(4'hF),
        .i_wvalid(wv), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(bry),
        .i_araddr(ara), .i_arvalid(arv), .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .o_rvalid(o_rvalid), .i_rready(rry), .o_acq(o_acq));
    initial begin
        forever #25 i_clk = ~i_clk;
    end
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [33:0] e, input logic [33:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // write: note the expected response, offer both channels, drop each once taken, hold bready to the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        exp_b.push_back(e);
        @(posedge i_clk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
        do begin
            @(posedge i_clk);
            if (o_awready) awv <= 1'b0;
            if (o_wready) wv <= 1'b0;
        end while (!o_bvalid);
        bry <= 1'b0;
    endtask
    // read: note the expected {resp,data}; the monitor does the compare
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        @(posedge i_clk);
        ara <= a; arv <= 1'b1; rry <= 1'b1;
        do begin
            @(posedge i_clk);
            if (o_arready) arv <= 1'b0;
        end while (!o_rvalid);
        rry <= 1'b0;
    endtask
    // monitor: every accepted read beat is checked against the oldest note
    always @(posedge i_clk) begin
        if (o_rvalid && rry && exp_q.size() > 0) cmp("rdata", exp_q.pop_front(), {o_rresp, o_rdata});
        if (o_bvalid && bry && exp_b.size() > 0) cmp("bresp", {32'h0, exp_b.pop_front()}, {32'h0, o_bresp});
    end
    // hang guard sized well above the few hundred cycles the sequence needs
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(92791));
        ch = $urandom_range(NCH - 1, 0);
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(A_CTRL, {RESP_OK, 32'h0});
        rd(A_DEPTH, {RESP_OK, 27'h0, DEPTH_RST});
        rd(A_TMO, {RESP_OK, 22'h0, TMO_RST});
        rd(8'h40, {RESP_ERR, 32'h0});
        wr(8'h40, 32'h0, RESP_ERR);
        rd(A_HLEN, {RESP_OK, 32'h0});
        wr(A_TMO, 32'd40, RESP_OK);
        wr(A_CTRL, 32'h1, RESP_OK);
        repeat (4) @(posedge i_clk);
        src.event_on(ch, 0);
        cmp("acq", 34'h1, {33'h0, o_acq});
        repeat (200) @(posedge i_clk);
        cmp("acq", 34'h0, {33'h0, o_acq});
        rd(A_HLEN, {RESP_OK, 32'd2});
        rd(A_RDATA, {RESP_OK, 32'(ch) << 17 | 32'd800});
        rd(A_RDATA, {RESP_OK, 32'(ch) << 17 | 32'd400});
        rd(A_RDATA, {RESP_OK, 32'h0});
        wr(A_REL, 32'h0, RESP_OK);
        rd(A_HLEN, {RESP_OK, 32'h0});
        // stop mode, both edges on the chosen channel: times count back from the stop
        wr(8'(A_EDGE + 4 * (ch / 16)), 32'h55555555 | (32'h3 << (2 * (ch % 16))), RESP_OK);
        rd(8'(A_EDGE + 4 * (ch / 16)), {RESP_OK, 32'h55555555 | (32'h3 << (2 * (ch % 16)))});
        wr(A_CTRL, 32'h3, RESP_OK);
        src.event_on(ch, 10);
        repeat (200) @(posedge i_clk);
        cmp("acq", 34'h1, {33'h0, o_acq});
        rd(A_HLEN, {RESP_OK, 32'd3});
        rd(A_RDATA, {RESP_OK, 32'(ch) << 17 | 32'h10000 | 32'd100});
        rd(A_RDATA, {RESP_OK, 32'(ch) << 17 | 32'd300});
        rd(A_RDATA, {RESP_OK, 32'(ch) << 17 | 32'h10000 | 32'd500});
        rd(A_RDATA, {RESP_OK, 32'h0});
        wr(A_REL, 32'h0, RESP_OK);
        rd(A_HLEN, {RESP_OK, 32'h0});
        repeat (4) @(posedge i_clk);
        print_verdict();
    end
endmodule
